// ==== pkg/dcp_pkg.sv ====
// Purpose: Shared constants of the drive common-area register bank.
// Assumes: Register words are 16 bits; offsets are word addresses.
// Notes: Error codes are the decoded answers of the serial protocol.

package dcp_pkg;

   // Word addresses of the common area
   localparam logic [15:0] ADDR_MODEL = 16'h0000;
   localparam logic [15:0] ADDR_CAPACITY = 16'h0001;
   localparam logic [15:0] ADDR_IN_VOLT = 16'h0002;
   localparam logic [15:0] ADDR_FW_VER = 16'h0003;
   localparam logic [15:0] ADDR_FREQ_REF = 16'h0005;
   localparam logic [15:0] ADDR_RUN_CMD = 16'h0006;
   localparam logic [15:0] ADDR_ACCEL = 16'h0007;
   localparam logic [15:0] ADDR_DECEL = 16'h0008;
   localparam logic [15:0] ADDR_CURRENT = 16'h0009;
   localparam logic [15:0] ADDR_OUT_FREQ = 16'h000A;
   localparam logic [15:0] ADDR_OUT_VOLT = 16'h000B;
   localparam logic [15:0] ADDR_DC_BUS = 16'h000C;
   localparam logic [15:0] ADDR_POWER = 16'h000D;
   localparam logic [15:0] ADDR_STATUS = 16'h000E;

   // Run command word field positions
   localparam int RC_STOP = 0;
   localparam int RC_FWD = 1;
   localparam int RC_REV = 2;
   localparam int RC_FRST = 3;
   localparam int RC_ESTOP = 4;
   localparam int RC_UNUSED = 5;
   localparam int RC_SRC_LO = 6;
   localparam int RC_FSRC_LO = 8;
   localparam int RC_NETERR = 15;

   // Frequency source encoding limits
   localparam logic [6:0] FSRC_RSV_LO = 7'h14;
   localparam logic [6:0] FSRC_RSV_HI = 7'h15;
   localparam logic [6:0] FSRC_MAX = 7'h1F;

   // Largest rated capacity code
   localparam logic [15:0] CAP_CODE_MAX = 16'h0017;

   // Operating status bit positions
   localparam int ST_STOP = 0;
   localparam int ST_FWD = 1;
   localparam int ST_REV = 2;
   localparam int ST_TRIP = 3;
   localparam int ST_ACC = 4;
   localparam int ST_DEC = 5;

   // Reset values of writable registers and of the status word
   localparam logic [15:0] RST_FREQ_REF = 16'h0000;
   localparam logic [15:0] RST_RUN_CMD = 16'h0000;
   localparam logic [15:0] RST_ACCEL = 16'h0000;
   localparam logic [15:0] RST_DECEL = 16'h0000;
   localparam logic [15:0] RST_STATUS = 16'h0001; // Stopped, nothing else set

   // Answer codes of a request
   typedef enum logic [1:0] {
      DCP_OK,
      DCP_ILLEGAL_ADDR,
      DCP_ILLEGAL_VALUE,
      DCP_WRITE_MODE_ERROR
   } dcp_err_t;

endpackage

// ==== rtl/dcp_regs.sv ====
// Purpose: Common-area register bank of a variable speed drive.
// Assumes: Requests arrive already decoded from the serial link, on core_clk_i.
// Notes: One answer per request, one cycle after it is taken.
//
// How it works
// R1: Same common map on every model variant.
// R2: Capacity code read-only, range 0 to 17h.
// R3: Run word bits 0-2 request stop/forward/reverse.
// R4: Fault cleared only on bit 3 rising.
// R5: Bit 4 emergency stop; bit 5 ignored.
// R6: Bits 6-7 select run/stop command source.
// R7: Bits 8-14 select frequency reference source.
// R8: Bit 15 set on network error.
// R9: Status bits 0-2 stop/forward/reverse.
// R10: Status bits 3-5 trip/accelerating/decelerating.
// R11: Read-only or locked writes refused, write-mode error.
// R12: Sixteen-bit words, fixed scaled units.
// R13: Monitors read-only, tracking live measurements.

`timescale 1ns/1ns
`default_nettype none

module dcp_regs #(
   parameter logic [15:0] MODEL_CODE = 16'h00A5, // Arbitrary identity value
   parameter logic [15:0] CAPACITY_CODE = 16'h0000, // Rated size code
   parameter logic [15:0] IN_VOLT_CLASS = 16'h0001, // Input voltage class
   parameter logic [15:0] FW_VERSION = 16'h0100 // Firmware version word
) (
   input wire logic core_clk_i, // 100 MHz clock
   input wire logic reset_i, // Async reset, active high
   input wire logic clk_en_i, // Freezes all state when low
   input wire logic req_valid_i, // Decoded request present
   input wire logic req_write_i, // 1 write, 0 read
   input wire logic [15:0] req_addr_i, // Word address
   input wire logic [15:0] req_wdata_i, // Write data
   output logic resp_valid_o, // Answer strobe
   output logic [15:0] resp_rdata_o, // Read data or previous value
   output dcp_pkg::dcp_err_t resp_err_o, // Answer code
   input wire logic [15:0] meas_current_i, // Output current, 0.1 A
   input wire logic [15:0] meas_out_freq_i, // Output frequency, 0.01 Hz
   input wire logic [15:0] meas_out_volt_i, // Output voltage, 0.1 V
   input wire logic [15:0] meas_dc_bus_i, // Dc_bus_voltage_monitor, 0.1 V
   input wire logic [15:0] meas_power_i, // Output power, 0.1 kW
   input wire logic drv_running_i, // Motor running
   input wire logic drv_reverse_i, // Running direction reverse
   input wire logic drv_accel_i, // Accelerating
   input wire logic drv_decel_i, // Decelerating
   input wire logic fault_trip_i, // Fault event pulse
   input wire logic net_err_i, // Network error event
   output logic stop_req_o, // Stop request pulse
   output logic fwd_req_o, // Forward run request pulse
   output logic rev_req_o, // Reverse run request pulse
   output logic fault_reset_o, // Fault reset pulse
   output logic estop_o, // Emergency stop level
   output logic [1:0] cmd_src_o, // Run/stop command source
   output logic [6:0] freq_src_o, // Frequency reference source
   output logic [15:0] freq_ref_o, // Frequency reference, 0.01 Hz
   output logic [15:0] accel_time_o, // Accel time, 0.1 s
   output logic [15:0] decel_time_o, // Decel time, 0.1 s
   output logic fault_latched_o // Drive tripped
);
   import dcp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [15:0] freq_ref_q; // Frequency reference
   logic [15:0] run_cmd_q; // Stored run word, bit 15 unused here
   logic [15:0] accel_q; // Acceleration time
   logic [15:0] decel_q; // Deceleration time
   logic net_err_q; // Sticky network error flag
   logic fault_q; // Latched trip
   logic [15:0] mon_q [5]; // Monitor copies
   logic [15:0] status_q; // Operating status
   logic resp_valid_q; // Answer strobe
   logic [15:0] resp_rdata_q; // Answer data
   dcp_err_t resp_err_q; // Answer code
   logic stop_q; // Stop pulse
   logic fwd_q; // Forward pulse
   logic rev_q; // Reverse pulse
   logic frst_q; // Fault reset pulse

   ////////////////////////////////////////////////////////////////////////////
   // Request decode
   wire req_fire = clk_en_i && req_valid_i; // Request taken this edge
   wire wr_fire = req_fire && req_write_i; // Write taken
   wire hit_ro = (req_addr_i <= ADDR_FW_VER)
      || (req_addr_i >= ADDR_CURRENT && req_addr_i <= ADDR_STATUS); // Read-only words
   wire hit_rw = (req_addr_i >= ADDR_FREQ_REF && req_addr_i <= ADDR_DECEL); // Writable
   wire hit_any = hit_ro || hit_rw; // Mapped address
   wire is_run_cmd = (req_addr_i == ADDR_RUN_CMD); // Run word selected
   wire [1:0] new_src = req_wdata_i[RC_SRC_LO+1:RC_SRC_LO]; // Written command source
   wire [6:0] new_fsrc = req_wdata_i[RC_FSRC_LO+6:RC_FSRC_LO]; // Written freq source
   // Reserved and out-of-range frequency sources are illegal values
   wire fsrc_bad = (new_fsrc >= FSRC_RSV_LO && new_fsrc <= FSRC_RSV_HI)
      || (new_fsrc > FSRC_MAX); // [R7]
   // Command source cannot be moved while the motor turns; it would
   // otherwise hand the run command to another party mid-motion
   wire src_locked = drv_running_i && (new_src != run_cmd_q[RC_SRC_LO+1:RC_SRC_LO]);

   // Answer code of this request
   wire dcp_err_t req_err = !hit_any ? DCP_ILLEGAL_ADDR
      : (req_write_i && hit_ro) ? DCP_WRITE_MODE_ERROR // [R11]
      : (req_write_i && is_run_cmd && src_locked) ? DCP_WRITE_MODE_ERROR // [R11]
      : (req_write_i && is_run_cmd && fsrc_bad) ? DCP_ILLEGAL_VALUE
      : DCP_OK;
   wire wr_ok = wr_fire && (req_err == DCP_OK); // Write that stores
   wire wr_run = wr_ok && is_run_cmd; // Accepted run word write

   // Run word as stored: unused bit 5 dropped, bit 15 owned by hardware
   wire [15:0] run_cmd_d = {1'b0, req_wdata_i[14:6], 1'b0, req_wdata_i[4:0]}; // [R5]
   // Read view of the run word shows the network error flag
   wire [15:0] run_cmd_view = {net_err_q, run_cmd_q[14:0]}; // [R8]

   // Read multiplexer; a write answers with the previous value
   logic [15:0] rd_word;
   always_comb
   begin
      case (req_addr_i)
         ADDR_MODEL: rd_word = MODEL_CODE; // [R1]
         ADDR_CAPACITY: rd_word = CAPACITY_CODE; // [R2]
         ADDR_IN_VOLT: rd_word = IN_VOLT_CLASS;
         ADDR_FW_VER: rd_word = FW_VERSION;
         ADDR_FREQ_REF: rd_word = freq_ref_q;
         ADDR_RUN_CMD: rd_word = run_cmd_view;
         ADDR_ACCEL: rd_word = accel_q;
         ADDR_DECEL: rd_word = decel_q;
         ADDR_CURRENT: rd_word = mon_q[0]; // [R13]
         ADDR_OUT_FREQ: rd_word = mon_q[1];
         ADDR_OUT_VOLT: rd_word = mon_q[2];
         ADDR_DC_BUS: rd_word = mon_q[3];
         ADDR_POWER: rd_word = mon_q[4];
         ADDR_STATUS: rd_word = status_q; // [R9]
         default: rd_word = 16'h0000; // Unmapped reads as zero
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answer path
   // One answer per taken request, in the following cycle
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         resp_valid_q <= 1'b0;
         resp_rdata_q <= 16'h0000;
         resp_err_q <= DCP_OK;
      end
      else if (clk_en_i)
      begin
         resp_valid_q <= req_valid_i;
         if (req_valid_i)
         begin
            resp_rdata_q <= rd_word;
            resp_err_q <= req_err;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writable registers
   // Refused writes leave every stored value as it was
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         freq_ref_q <= RST_FREQ_REF;
         run_cmd_q <= RST_RUN_CMD;
         accel_q <= RST_ACCEL;
         decel_q <= RST_DECEL;
      end
      else if (wr_ok)
      begin
         // Plain 16-bit words in their scaled units; the run word drops bits 5 and 15
         case (req_addr_i)
            ADDR_FREQ_REF: freq_ref_q <= req_wdata_i; // [R12]
            ADDR_RUN_CMD: run_cmd_q <= run_cmd_d; // [R6] [R7]
            ADDR_ACCEL: accel_q <= req_wdata_i;
            ADDR_DECEL: decel_q <= req_wdata_i;
            default: freq_ref_q <= freq_ref_q; // Nothing else is writable
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command pulses from the run word
   // Requests act on each accepted write carrying the bit
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         stop_q <= 1'b0;
         fwd_q <= 1'b0;
         rev_q <= 1'b0;
         frst_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         stop_q <= wr_run && req_wdata_i[RC_STOP]; // [R3]
         fwd_q <= wr_run && req_wdata_i[RC_FWD]; // [R3]
         rev_q <= wr_run && req_wdata_i[RC_REV]; // [R3]
         // Only a 0 to 1 change of the stored bit resets the fault
         frst_q <= wr_run && req_wdata_i[RC_FRST] && !run_cmd_q[RC_FRST]; // [R4]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault latch and network error flag
   // A new event in the clearing cycle wins over the clear
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         fault_q <= 1'b0;
         net_err_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (fault_trip_i)
            fault_q <= 1'b1;
         else if (frst_q)
            fault_q <= 1'b0; // [R4]
         // Network error clears when the master writes bit 15 low
         if (net_err_i)
            net_err_q <= 1'b1; // [R8]
         else if (wr_run && !req_wdata_i[RC_NETERR])
            net_err_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Monitors and status, refreshed every enabled cycle
   wire [15:0] meas_vec [5]; // Live measurements in map order
   assign meas_vec[0] = meas_current_i;
   assign meas_vec[1] = meas_out_freq_i;
   assign meas_vec[2] = meas_out_volt_i;
   assign meas_vec[3] = meas_dc_bus_i;
   assign meas_vec[4] = meas_power_i;

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_mon
         // One cycle behind the live value, never writable
         always_ff @(posedge core_clk_i or posedge reset_i)
         begin
            if (reset_i)
               mon_q[gi] <= 16'h0000;
            else if (clk_en_i)
               mon_q[gi] <= meas_vec[gi]; // [R13]
         end
      end
   endgenerate

   // Status word; bits above 5 are not produced by this block
   wire [15:0] status_d = {10'h000,
      drv_decel_i, // [R10]
      drv_accel_i, // [R10]
      fault_q, // [R10]
      drv_running_i && drv_reverse_i, // [R9]
      drv_running_i && !drv_reverse_i, // [R9]
      !drv_running_i}; // [R9]

   // Registered so a read sees one coherent snapshot
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         status_q <= RST_STATUS;
      else if (clk_en_i)
         status_q <= status_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign resp_valid_o = resp_valid_q;
   assign resp_rdata_o = resp_rdata_q;
   assign resp_err_o = resp_err_q;
   assign stop_req_o = stop_q;
   assign fwd_req_o = fwd_q;
   assign rev_req_o = rev_q;
   assign fault_reset_o = frst_q;
   assign estop_o = run_cmd_q[RC_ESTOP]; // [R5]
   assign cmd_src_o = run_cmd_q[RC_SRC_LO+1:RC_SRC_LO]; // [R6]
   assign freq_src_o = run_cmd_q[RC_FSRC_LO+6:RC_FSRC_LO]; // [R7]
   assign freq_ref_o = freq_ref_q;
   assign accel_time_o = accel_q;
   assign decel_time_o = decel_q;
   assign fault_latched_o = fault_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_answer_follows: assert property ( // [R12]
      @(posedge core_clk_i) disable iff (reset_i)
      req_fire |=> resp_valid_o)
      else $error("request not answered next cycle");

   a_ro_write_refused: assert property ( // [R11]
      @(posedge core_clk_i) disable iff (reset_i)
      wr_fire && hit_ro |=> resp_err_o == DCP_WRITE_MODE_ERROR)
      else $error("read-only write not refused");

   a_locked_src_kept: assert property ( // [R11]
      @(posedge core_clk_i) disable iff (reset_i)
      wr_fire && is_run_cmd && src_locked |=> $stable(cmd_src_o))
      else $error("locked command source changed");

   a_capacity_range: assert property ( // [R2]
      @(posedge core_clk_i) disable iff (reset_i)
      req_fire && !req_write_i && req_addr_i == ADDR_CAPACITY
      |=> resp_rdata_o <= CAP_CODE_MAX)
      else $error("capacity code out of range");

   a_fault_reset_edge: assert property ( // [R4]
      @(posedge core_clk_i) disable iff (reset_i)
      fault_reset_o |-> run_cmd_q[RC_FRST])
      else $error("fault reset without bit 3 set");

   a_fault_clears: assert property ( // [R4]
      @(posedge core_clk_i) disable iff (reset_i)
      clk_en_i && fault_reset_o && !fault_trip_i |=> !fault_latched_o)
      else $error("fault not cleared by reset pulse");

   a_estop_follows: assert property ( // [R5]
      @(posedge core_clk_i) disable iff (reset_i)
      wr_run && req_wdata_i[RC_ESTOP] |=> estop_o && !run_cmd_q[RC_UNUSED])
      else $error("emergency stop not taken");

   a_net_err_set: assert property ( // [R8]
      @(posedge core_clk_i) disable iff (reset_i)
      clk_en_i && net_err_i |=> run_cmd_view[RC_NETERR])
      else $error("network error flag not set");

   a_status_dir: assert property ( // [R9]
      @(posedge core_clk_i) disable iff (reset_i)
      clk_en_i && drv_running_i && drv_reverse_i
      |=> status_q[ST_REV] && !status_q[ST_FWD] && !status_q[ST_STOP])
      else $error("reverse status wrong");

   a_status_trip: assert property ( // [R10]
      @(posedge core_clk_i) disable iff (reset_i)
      clk_en_i |=> status_q[ST_TRIP] == $past(fault_q)
         && status_q[ST_ACC] == $past(drv_accel_i)
         && status_q[ST_DEC] == $past(drv_decel_i))
      else $error("trip or ramp status wrong");

   a_monitor_track: assert property ( // [R13]
      @(posedge core_clk_i) disable iff (reset_i)
      clk_en_i |=> mon_q[0] == $past(meas_current_i))
      else $error("current monitor stale");

   a_bad_fsrc: assert property ( // [R7]
      @(posedge core_clk_i) disable iff (reset_i)
      wr_fire && is_run_cmd && !src_locked && fsrc_bad
      |=> resp_err_o == DCP_ILLEGAL_VALUE && $stable(freq_src_o))
      else $error("reserved frequency source accepted");

endmodule

`default_nettype wire

// ==== sim/dcp_host.sv ====
// Purpose: Host master model that issues decoded register requests to the bank.
// Assumes: A request is taken on the next rising edge and answered one cycle later.
// Notes: Released address, data and direction show the inverse of their last value.
`timescale 1ns/1ns
`default_nettype none
module dcp_host (
   input wire logic core_clk_i, // Bank clock
   output logic req_valid_o, // Request present
   output logic req_write_o, // 1 write, 0 read
   output logic [15:0] req_addr_o, // Word address
   output logic [15:0] req_wdata_o, // Write data
   input wire logic resp_valid_i, // Answer strobe
   input wire logic [15:0] resp_rdata_i, // Answer data
   input wire logic [1:0] resp_err_i // Answer code
);
   ////////////////////////////////////////////////////////////////////////////////
   // Idle at time zero, nothing requested
   initial
   begin
      req_valid_o = 1'b0;
      req_write_o = 1'b0;
      req_addr_o = 16'h0000;
      req_wdata_o = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One word transfer; the bench orders the writes that a fault reset needs
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
      output logic ok, output logic [15:0] rd, output logic [1:0] er);
      @(posedge core_clk_i);
      req_valid_o <= 1'b1;
      req_write_o <= wr;
      req_addr_o <= a;
      req_wdata_o <= d;
      @(posedge core_clk_i);
      // Taken here; stale lines flip so a late sample cannot look valid
      req_valid_o <= 1'b0;
      req_write_o <= ~wr;
      req_addr_o <= ~a;
      req_wdata_o <= ~d;
      #1;
      ok = resp_valid_i;
      rd = resp_rdata_i;
      er = resp_err_i;
   endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: Self-checking bench of the drive common-area register bank.
// Assumes: Host model makes one request at a time; drive status inputs from the bench.
// Notes: Expected run word is tracked here from the written values.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import dcp_pkg::*;
   localparam logic [15:0] TB_MODEL = 16'h005A; // Arbitrary identity value
   logic core_clk = 1'b0; // 100 MHz clock
   logic reset = 1'b1; // Held for twelve cycles
   logic clk_en = 1'b1; // Clock enable of the bank
   logic req_valid, req_write, resp_valid, stop_req, fwd_req, rev_req, fault_rst, estop, fault_lat;
   logic [15:0] req_addr, req_wdata, resp_rdata, freq_ref, accel_t, decel_t;
   logic [1:0] cmd_src; // Command source field
   logic [6:0] freq_src; // Frequency source field
   dcp_err_t resp_err; // Answer code
   logic [15:0] m_cur = 16'h0000, m_frq = 16'h0000, m_vlt = 16'h0000, m_dc = 16'h0000;
   logic [15:0] m_pwr = 16'h0000; // Power monitor input
   logic drv_run = 1'b0, drv_rev = 1'b0, drv_acc = 1'b0, drv_dec = 1'b0;
   logic trip = 1'b0, net_err = 1'b0; // Event inputs
   logic [15:0] rw_exp = 16'h0000; // Expected stored run word
   logic net_exp = 1'b0; // Expected network flag
   int errors = 0, checked = 0, cycles = 0;
   always #5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////////
   dcp_regs #(.MODEL_CODE(TB_MODEL), .CAPACITY_CODE(CAP_CODE_MAX), .IN_VOLT_CLASS(16'h0000),
      .FW_VERSION(16'h0101)) dcp_regs_i (.core_clk_i(core_clk), .reset_i(reset),
      .clk_en_i(clk_en), .req_valid_i(req_valid), .req_write_i(req_write), .req_addr_i(req_addr),
      .req_wdata_i(req_wdata), .resp_valid_o(resp_valid), .resp_rdata_o(resp_rdata),
      .resp_err_o(resp_err), .meas_current_i(m_cur), .meas_out_freq_i(m_frq),
      .meas_out_volt_i(m_vlt), .meas_dc_bus_i(m_dc), .meas_power_i(m_pwr),
      .drv_running_i(drv_run), .drv_reverse_i(drv_rev), .drv_accel_i(drv_acc),
      .drv_decel_i(drv_dec), .fault_trip_i(trip), .net_err_i(net_err), .stop_req_o(stop_req),
      .fwd_req_o(fwd_req), .rev_req_o(rev_req), .fault_reset_o(fault_rst), .estop_o(estop),
      .cmd_src_o(cmd_src), .freq_src_o(freq_src), .freq_ref_o(freq_ref),
      .accel_time_o(accel_t), .decel_time_o(decel_t), .fault_latched_o(fault_lat));
   dcp_host dcp_host_i (.core_clk_i(core_clk), .req_valid_o(req_valid), .req_write_o(req_write),
      .req_addr_o(req_addr), .req_wdata_o(req_wdata), .resp_valid_i(resp_valid),
      .resp_rdata_i(resp_rdata), .resp_err_i(resp_err));
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic wrap_up();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Cut a hang short; the whole run needs about 250 cycles
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         wrap_up();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One request; the answer must come and carry the expected code
   task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
      input logic [1:0] ee, output logic [15:0] r);
      logic ok;
      logic [1:0] er;
      dcp_host_i.xfer(wr, a, d, ok, r, er);
      chk({15'h0000, ok}, 16'h0001);
      chk({14'h0000, er}, {14'h0000, ee});
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] r;
      acc(1'b0, a, 16'h0000, DCP_OK, r);
      chk(r, exp);
   endtask
   // Run word write: answer, pulses and field outputs all judged here
   task automatic wr_run(input logic [15:0] d, input logic [1:0] ee);
      logic [15:0] r;
      logic [3:0] p;
      p = 4'h0;
      acc(1'b1, ADDR_RUN_CMD, d, ee, r);
      if (ee == DCP_OK)
      begin
         chk(r, rw_exp | {net_exp, 15'h0000});
         p = {d[3] & ~rw_exp[3], d[2:0]};
         rw_exp = d & 16'h7FDF;
         net_exp = 1'b0;
      end
      chk({12'h000, fault_rst, rev_req, fwd_req, stop_req}, {12'h000, p});
      chk({estop, cmd_src, freq_src, 6'h00}, {rw_exp[4], rw_exp[7:6], rw_exp[14:8], 6'h00});
   endtask
   // Pulse the fault event (f=1) or the network event (f=0)
   task automatic ev(input logic f);
      @(posedge core_clk);
      trip <= f;
      net_err <= ~f;
      @(posedge core_clk);
      trip <= 1'b0;
      net_err <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_ident();
      chk(freq_ref, RST_FREQ_REF);
      rd_chk(ADDR_STATUS, 16'h0001);
      rd_chk(ADDR_MODEL, TB_MODEL);
      rd_chk(ADDR_CAPACITY, CAP_CODE_MAX);
      rd_chk(ADDR_IN_VOLT, 16'h0000);
      rd_chk(ADDR_FW_VER, 16'h0101);
   endtask
   task automatic t_refuse();
      logic [15:0] r;
      logic [15:0] ro [10] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h9, 16'hA, 16'hB, 16'hC, 16'hD, 16'hE};
      foreach (ro[k])
         acc(1'b1, ro[k], 16'h00FF, DCP_WRITE_MODE_ERROR, r);
      rd_chk(ADDR_CAPACITY, CAP_CODE_MAX);
      acc(1'b0, 16'h0004, 16'h0000, DCP_ILLEGAL_ADDR, r);
      acc(1'b1, 16'h000F, 16'h0001, DCP_ILLEGAL_ADDR, r);
   endtask
   task automatic t_rw();
      logic [15:0] r;
      acc(1'b1, ADDR_FREQ_REF, 16'h1770, DCP_OK, r);
      chk(r, RST_FREQ_REF);
      acc(1'b1, ADDR_ACCEL, 16'hFFFF, DCP_OK, r);
      chk(r, RST_ACCEL);
      acc(1'b1, ADDR_DECEL, 16'h0001, DCP_OK, r);
      chk(r, RST_DECEL);
      chk(freq_ref ^ accel_t ^ decel_t, 16'h1770 ^ 16'hFFFF ^ 16'h0001);
      acc(1'b1, ADDR_FREQ_REF, 16'h0000, DCP_OK, r);
      chk(r, 16'h1770);
      rd_chk(ADDR_ACCEL, 16'hFFFF);
   endtask
   task automatic t_run();
      wr_run(16'h0002, DCP_OK);
      wr_run(16'h0004, DCP_OK);
      wr_run(16'h0001, DCP_OK);
      wr_run(16'h0030, DCP_OK);
      rd_chk(ADDR_RUN_CMD, 16'h0010);
      for (int k = 0; k < 4; k++)
         wr_run({8'h00, 2'(k), 6'h00}, DCP_OK);
      for (int k = 0; k < 34; k++)
         wr_run({1'b0, 7'(k), 8'h00}, (k inside {20, 21} || k > 31) ? 2'h2 : 2'h0);
      wr_run(16'h7F00, DCP_ILLEGAL_VALUE);
      @(posedge core_clk);
      drv_run <= 1'b1;
      wr_run(16'h00C0, DCP_WRITE_MODE_ERROR);
      wr_run(16'h1C00, DCP_OK);
      @(posedge core_clk);
      drv_run <= 1'b0;
   endtask
   // Status bits and monitors follow the live inputs
   task automatic t_status();
      logic [3:0] i;
      for (int k = 0; k < 16; k++)
      begin
         i = 4'(k);
         @(posedge core_clk);
         {drv_dec, drv_acc, drv_rev, drv_run} <= i;
         rd_chk(ADDR_STATUS, {10'h000, i[3:2], 1'b0, i[0] & i[1], i[0] & ~i[1], ~i[0]});
      end
      @(posedge core_clk);
      {drv_dec, drv_acc, drv_rev, drv_run} <= 4'h0;
      m_cur <= 16'h1234;
      m_frq <= 16'h1770;
      m_vlt <= 16'h0DAC;
      m_dc <= 16'h0F3C;
      m_pwr <= 16'h8001;
      rd_chk(ADDR_CURRENT, 16'h1234);
      rd_chk(ADDR_OUT_FREQ, 16'h1770);
      rd_chk(ADDR_OUT_VOLT, 16'h0DAC);
      rd_chk(ADDR_DC_BUS, 16'h0F3C);
      rd_chk(ADDR_POWER, 16'h8001);
   endtask
   // Fault latch clears only on a rising reset bit
   task automatic t_fault();
      ev(1'b1);
      chk({15'h0000, fault_lat}, 16'h0001);
      rd_chk(ADDR_STATUS, 16'h0009);
      wr_run(16'h0000, DCP_OK);
      wr_run(16'h0008, DCP_OK);
      @(posedge core_clk);
      #1;
      chk({15'h0000, fault_lat}, 16'h0000);
      ev(1'b1);
      wr_run(16'h0008, DCP_OK);
      chk({15'h0000, fault_lat}, 16'h0001);
      wr_run(16'h0000, DCP_OK);
      wr_run(16'h0008, DCP_OK);
      @(posedge core_clk);
      #1;
      chk({15'h0000, fault_lat}, 16'h0000);
   endtask
   task automatic t_net();
      ev(1'b0);
      net_exp = 1'b1;
      rd_chk(ADDR_RUN_CMD, rw_exp | 16'h8000);
      wr_run(16'h0000, DCP_OK);
      rd_chk(ADDR_RUN_CMD, 16'h0000);
   endtask
   // Enable low: a request is not taken and no register moves
   task automatic t_freeze();
      logic ok;
      logic [15:0] r;
      logic [1:0] er;
      @(posedge core_clk);
      clk_en <= 1'b0;
      m_cur <= 16'h4321;
      dcp_host_i.xfer(1'b1, ADDR_FREQ_REF, 16'h00AA, ok, r, er);
      chk({15'h0000, ok}, 16'h0000);
      chk(freq_ref, 16'h0000);
      @(posedge core_clk);
      clk_en <= 1'b1;
      rd_chk(ADDR_FREQ_REF, 16'h0000);
      rd_chk(ADDR_CURRENT, 16'h4321);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      t_ident();
      t_refuse();
      t_rw();
      t_run();
      t_status();
      t_fault();
      t_net();
      t_freeze();
      wrap_up();
   end
endmodule
`default_nettype wire
